/* File: core/timer_regs_pkg.sv */
// Constants, register indices and helper functions of the periodic timer block.
// Assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
//
// How it works
// - Base-select bit 0 routes a channel to micro base 0, bit 1 to base 1.
// - Changing a base-select bit moves the channel to the other base at once.
// - Each channel requests an interrupt while its enable and its flag are both set.
// - Enabling an interrupt with its flag already set requests it at once.
// - A flag sets when the channel counter and its micro counter both reach zero.
// - Writing one clears a flag, zero leaves it; flags read back at any time.
// - A clearing write and a setting event in one cycle leave the flag set.
// - Module disable clears all flags; channel disable clears that channel's flag.
// - Writing a micro reload value takes effect only at the next micro reload.
// - A micro force-load bit copies the micro reload value into its counter at once.
// - Reload writes never restart; at zero the channel sets its flag and reloads.
// - A channel force-load bit copies the reload value into its counter at once.
// - Count registers read the live channel counter; writes to them are ignored.
// - A count register is read whole in one cycle from one counter state.
// - The count registers reset to zero.
// - An enabled channel in an enabled module loads its start value and counts down.
// - Each micro zero reloads the micro counter and steps attached channels down.
// - Each time-out raises the channel trigger for at least one cycle.
// - Time-out period is (micro reload + 1) times (channel reload + 1) cycles.

package timer_regs_pkg;

   // ---------------------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------------------
   localparam int NUM_CH   = 4;
   localparam int NUM_BASE = 2;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int CH_W     = 16;
   localparam int MT_W     = 8;
   localparam int IDX_W    = 6;

   // ---------------------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ---------------------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_CTRL     = 6'h00;
   localparam logic [IDX_W-1:0] IDX_CH_FORCE = 6'h01;
   localparam logic [IDX_W-1:0] IDX_CH_EN    = 6'h02;
   localparam logic [IDX_W-1:0] IDX_BASE_SEL = 6'h03;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN   = 6'h04;
   localparam logic [IDX_W-1:0] IDX_FLAGS    = 6'h05;
   localparam logic [IDX_W-1:0] IDX_MT0_LD   = 6'h06;
   localparam logic [IDX_W-1:0] IDX_MT1_LD   = 6'h07;
   localparam logic [NUM_CH-1:0][IDX_W-1:0] IDX_RELOAD = {6'h14, 6'h10, 6'h0c, 6'h08};
   localparam logic [NUM_CH-1:0][IDX_W-1:0] IDX_COUNT  = {6'h16, 6'h12, 6'h0e, 6'h0a};

   // ---------------------------------------------------------------------------
   // Fields, reset values and bus responses
   // ---------------------------------------------------------------------------
   localparam int               MOD_EN_BIT = 7;
   localparam logic [MT_W-1:0]  RST_BYTE   = 8'h00;
   localparam logic [CH_W-1:0]  RST_CNT    = 16'h0000;
   localparam logic [1:0]       RESP_OKAY  = 2'h0;
   localparam logic [1:0]       RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------------
   function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] addr);
      return addr[ADDR_W-1:2];
   endfunction : word_idx

   function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
      logic hit;
      hit = (idx <= IDX_MT1_LD);
      for (int i = 0; i < NUM_CH; i++) begin
         hit = hit | (idx == IDX_RELOAD[i]) | (idx == IDX_COUNT[i]);
      end
      return hit;
   endfunction : is_mapped

endpackage : timer_regs_pkg

/* File: core/micro_time_base.sv */
// One 8-bit micro time base down-counter.
// Assumes its reload value and strobes come from the register block on the same clock.
`timescale 1ns/1ps

module micro_time_base
   import timer_regs_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic            active,
   input  wire logic            force_load,
   input  wire logic [MT_W-1:0] micro_reload_value,
   output logic                 tick
);

   logic [MT_W-1:0] cnt_r;

   assign tick = active & ~force_load & (cnt_r == RST_BYTE);

   // ---------------------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= RST_BYTE;
      end else if (!active || force_load || cnt_r == RST_BYTE) begin
         cnt_r <= micro_reload_value;
      end else begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   mt_step_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         active && !force_load && cnt_r != RST_BYTE |=> cnt_r == $past(cnt_r) - 8'h01)
      else $error("micro counter did not step down");

   mt_reload_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         tick |=> cnt_r == $past(micro_reload_value))
      else $error("micro counter did not reload at zero");

   mt_force_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         active && force_load |-> !tick ##1 cnt_r == $past(micro_reload_value))
      else $error("micro force load not applied");

endmodule : micro_time_base

/* File: core/channel_timer.sv */
// One 16-bit channel down-counter clocked by a selectable micro time base.
// Assumes the base ticks and strobes come from the register block on the same clock.
`timescale 1ns/1ps

module channel_timer
   import timer_regs_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                enable,
   input  wire logic                force_load,
   input  wire logic                base_select,
   input  wire logic [NUM_BASE-1:0] base_tick,
   input  wire logic [CH_W-1:0]     channel_reload_value,
   output logic [CH_W-1:0]          channel_count_value,
   output logic                     timeout_evt
);

   logic step;

   assign step        = base_select ? base_tick[1] : base_tick[0];
   assign timeout_evt = enable & ~force_load & step & (channel_count_value == RST_CNT);

   // ---------------------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_count_value <= RST_CNT;
      end else if (!enable || force_load || timeout_evt) begin
         channel_count_value <= channel_reload_value;
      end else if (step) begin
         channel_count_value <= channel_count_value - 16'h0001;
      end
   end

   ch_step_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         enable && !force_load && step && channel_count_value != RST_CNT
         |=> channel_count_value == $past(channel_count_value) - 16'h0001)
      else $error("channel counter did not step on base tick");

   ch_hold_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         enable && !force_load && !step |=> $stable(channel_count_value))
      else $error("channel counter moved without a tick");

   ch_reload_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         timeout_evt |=> channel_count_value == $past(channel_reload_value))
      else $error("channel counter did not reload at time-out");

   ch_force_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         enable && force_load |=> channel_count_value == $past(channel_reload_value))
      else $error("channel force load not applied");

endmodule : channel_timer

/* File: core/periodic_timer_channel_regs.sv */
// Four-channel periodic timer with two micro time bases and an AXI4-Lite register file.
// Assumes an AXI4-Lite master on aclk; interrupt and trigger lines go to on-chip logic.
`timescale 1ns/1ps

module periodic_timer_channel_regs
   import timer_regs_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [NUM_CH-1:0]      irq_req,
   output logic [NUM_CH-1:0]      timeout_trigger_out
);

   // ---------------------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------------------
   logic                              module_enable_bit_r;
   logic [NUM_CH-1:0]                 channel_enable_bits_r;
   logic [NUM_CH-1:0]                 base_select_bits_r;
   logic [NUM_CH-1:0]                 timeout_irq_enable_bits_r;
   logic [NUM_CH-1:0]                 timeout_flag_bits_r;
   logic [NUM_CH-1:0]                 timeout_flag_bits_nxt;
   logic [NUM_BASE-1:0][MT_W-1:0]     micro_reload_value_r;
   logic [NUM_CH-1:0][CH_W-1:0]       channel_reload_value_r;
   logic [NUM_CH-1:0][CH_W-1:0]       channel_count_value;
   logic [NUM_CH-1:0]                 trigger_r;

   logic                              aw_held_r;
   logic                              w_held_r;
   logic [ADDR_W-1:0]                 awaddr_r;
   logic [DATA_W-1:0]                 wdata_r;
   logic [3:0]                        wstrb_r;
   logic                              bvalid_r;
   logic [1:0]                        bresp_r;
   logic                              rvalid_r;
   logic [1:0]                        rresp_r;
   logic [DATA_W-1:0]                 rdata_r;

   logic                              wr_go;
   logic [IDX_W-1:0]                  wr_idx;
   logic [IDX_W-1:0]                  rd_idx;
   logic                              lane0;
   logic                              wr_ctrl;
   logic [NUM_CH-1:0]                 chan_en;
   logic [NUM_CH-1:0]                 flag_clear;
   logic [NUM_CH-1:0]                 chan_force;
   logic [NUM_BASE-1:0]               micro_force;
   logic [NUM_BASE-1:0]               micro_active;
   logic [NUM_BASE-1:0]               base_tick;
   logic [NUM_CH-1:0]                 timeout_evt;
   logic [DATA_W-1:0]                 rd_mux;

   // ---------------------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------------------
   assign awready = ~aw_held_r;
   assign wready  = ~w_held_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign wr_go   = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_idx  = word_idx(awaddr_r);
   assign lane0   = wr_go & wstrb_r[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
      end else if (awvalid && awready) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= awaddr;
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (wvalid && wready) begin
         w_held_r <= 1'b1;
         wdata_r  <= wdata;
         wstrb_r  <= wstrb;
      end else if (wr_go) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------------------
   assign wr_ctrl = lane0 & (wr_idx == IDX_CTRL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         module_enable_bit_r       <= 1'b0;
         channel_enable_bits_r     <= '0;
         base_select_bits_r        <= '0;
         timeout_irq_enable_bits_r <= '0;
      end else if (lane0) begin
         if (wr_idx == IDX_CTRL) begin
            module_enable_bit_r <= wdata_r[MOD_EN_BIT];
         end
         if (wr_idx == IDX_CH_EN) begin
            channel_enable_bits_r <= wdata_r[NUM_CH-1:0];
         end
         if (wr_idx == IDX_BASE_SEL) begin
            base_select_bits_r <= wdata_r[NUM_CH-1:0];
         end
         if (wr_idx == IDX_IRQ_EN) begin
            timeout_irq_enable_bits_r <= wdata_r[NUM_CH-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         micro_reload_value_r <= {NUM_BASE{RST_BYTE}};
      end else if (lane0) begin
         if (wr_idx == IDX_MT0_LD) begin
            micro_reload_value_r[0] <= wdata_r[MT_W-1:0];
         end
         if (wr_idx == IDX_MT1_LD) begin
            micro_reload_value_r[1] <= wdata_r[MT_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_reload_value_r <= {NUM_CH{RST_CNT}};
      end else if (wr_go && wstrb_r[1:0] == 2'h3) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (wr_idx == IDX_RELOAD[i]) begin
               channel_reload_value_r[i] <= wdata_r[CH_W-1:0];
            end
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Enables and force-load strobes
   // ---------------------------------------------------------------------------
   assign chan_en     = {NUM_CH{module_enable_bit_r}} & channel_enable_bits_r;
   assign chan_force  = (lane0 && wr_idx == IDX_CH_FORCE) ? (wdata_r[NUM_CH-1:0] & chan_en) : '0;
   assign micro_force = wr_ctrl ? wdata_r[NUM_BASE-1:0] & micro_active : '0;
   assign flag_clear  = (lane0 && wr_idx == IDX_FLAGS) ? wdata_r[NUM_CH-1:0] : '0;

   always_comb begin
      micro_active = '0;
      for (int k = 0; k < NUM_BASE; k++) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (chan_en[i] && (base_select_bits_r[i] == k[0])) begin
               micro_active[k] = 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Time bases and channels
   // ---------------------------------------------------------------------------
   for (genvar k = 0; k < NUM_BASE; k++) begin : g_base
      micro_time_base u_base (
         .aclk               (aclk),
         .aresetn            (aresetn),
         .active             (micro_active[k]),
         .force_load         (micro_force[k]),
         .micro_reload_value (micro_reload_value_r[k]),
         .tick               (base_tick[k])
      );
   end

   for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
      channel_timer u_chan (
         .aclk                 (aclk),
         .aresetn              (aresetn),
         .enable               (chan_en[i]),
         .force_load           (chan_force[i]),
         .base_select          (base_select_bits_r[i]),
         .base_tick            (base_tick),
         .channel_reload_value (channel_reload_value_r[i]),
         .channel_count_value  (channel_count_value[i]),
         .timeout_evt          (timeout_evt[i])
      );
   end

   // ---------------------------------------------------------------------------
   // Flags, interrupts and triggers
   // ---------------------------------------------------------------------------
   assign timeout_flag_bits_nxt = ((timeout_flag_bits_r & ~flag_clear) | timeout_evt) & chan_en;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_flag_bits_r <= '0;
      end else begin
         timeout_flag_bits_r <= timeout_flag_bits_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trigger_r <= '0;
      end else begin
         trigger_r <= timeout_evt;
      end
   end

   assign irq_req             = timeout_flag_bits_r & timeout_irq_enable_bits_r;
   assign timeout_trigger_out = trigger_r;

   // ---------------------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------------------
   assign rd_idx  = word_idx(araddr);
   assign arready = ~rvalid_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;

   always_comb begin
      rd_mux = '0;
      case (rd_idx)
         IDX_CTRL:     rd_mux[MOD_EN_BIT] = module_enable_bit_r;
         IDX_CH_EN:    rd_mux[NUM_CH-1:0] = channel_enable_bits_r;
         IDX_BASE_SEL: rd_mux[NUM_CH-1:0] = base_select_bits_r;
         IDX_IRQ_EN:   rd_mux[NUM_CH-1:0] = timeout_irq_enable_bits_r;
         IDX_FLAGS:    rd_mux[NUM_CH-1:0] = timeout_flag_bits_r;
         IDX_MT0_LD:   rd_mux[MT_W-1:0]   = micro_reload_value_r[0];
         IDX_MT1_LD:   rd_mux[MT_W-1:0]   = micro_reload_value_r[1];
         default: begin
            for (int i = 0; i < NUM_CH; i++) begin
               if (rd_idx == IDX_RELOAD[i]) begin
                  rd_mux[CH_W-1:0] = channel_reload_value_r[i];
               end
               if (rd_idx == IDX_COUNT[i]) begin
                  rd_mux[CH_W-1:0] = channel_count_value[i];
               end
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= '0;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         rdata_r  <= rd_mux;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------------
   base_route_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         chan_en[0] && !base_select_bits_r[0] |-> micro_active[0])
      else $error("enabled channel 0 not driving base 0");

   irq_enable_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         lane0 && wr_idx == IDX_IRQ_EN && wdata_r[0] && timeout_flag_bits_nxt[0] |=> irq_req[0])
      else $error("interrupt not raised on enable with flag set");

   irq_level_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         irq_req[1] |-> timeout_flag_bits_r[1] && timeout_irq_enable_bits_r[1])
      else $error("interrupt without flag and enable");

   flag_set_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         timeout_evt[2] && flag_clear[2] |=> timeout_flag_bits_r[2])
      else $error("clear won over a time-out event");

   flag_clear_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         flag_clear[0] && !timeout_evt[0] |=> !timeout_flag_bits_r[0])
      else $error("write of one did not clear flag");

   flag_disable_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         !module_enable_bit_r |=> timeout_flag_bits_r == '0)
      else $error("flags not cleared while module disabled");

   trigger_edge_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         timeout_evt[3] && !trigger_r[3] |=> $rose(timeout_trigger_out[3]))
      else $error("no trigger edge on time-out");

   count_read_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         arvalid && arready && rd_idx == IDX_COUNT[1]
         |=> rvalid && rdata[CH_W-1:0] == $past(channel_count_value[1]) && rdata[DATA_W-1:CH_W] == '0)
      else $error("count read does not match counter");

   resp_hold_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data changed while stalled");

   chan_start_a:
      assert property (@(posedge aclk) disable iff (!aresetn)
         $rose(chan_en[0]) |-> channel_count_value[0] == channel_reload_value_r[0])
      else $error("enabled channel did not start from its reload value");

endmodule : periodic_timer_channel_regs

/* File: testbench/timer_event_sink.sv */
// Stand-in for the logic fed by the timer: measures channel 0 trigger spacing, counts cycles with the channel 0 request high.
// Assumes triggers and requests are synchronous to aclk.
`timescale 1ns/1ps

module timer_event_sink (
   input  wire logic        aclk,
   input  wire logic [3:0]  irq_req,
   input  wire logic [3:0]  trig,
   output logic [15:0]      gap,
   output logic [15:0]      irq_cycles
);
   logic [15:0] cnt_r = 16'h0000;
   logic [15:0] irq_r = 16'h0000;

   assign irq_cycles = irq_r;

   always_ff @(posedge aclk) begin
      cnt_r <= (trig[0] === 1'b1) ? 16'h0001 : cnt_r + 16'h0001;
      if (trig[0] === 1'b1) begin
         gap <= cnt_r;
      end
   end

   always_ff @(posedge aclk) begin
      irq_r <= irq_r + ((irq_req[0] === 1'b1) ? 16'h0001 : 16'h0000);
   end
endmodule : timer_event_sink

/* File: testbench/periodic_timer_channel_regs_tb.sv */
// Self-checking bench: AXI4-Lite register tasks drive the timer, the sink watches its outputs.
// Assumes the design answers writes and reads within a few cycles of taking them.
`timescale 1ns/1ps

module periodic_timer_channel_regs_tb
   import timer_regs_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, bready = 1'b1, rready = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0]  wstrb = 4'hf, irq_req, timeout_trigger_out;
   logic [1:0]  bresp, rresp, r, bp;
   logic [15:0] gap, irq_cycles;
   int          num_errors = 0, samples_checked = 0;

   always #2.5 aclk = ~aclk;

   periodic_timer_channel_regs i_periodic_timer_channel_regs (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .irq_req, .timeout_trigger_out);
   timer_event_sink i_timer_event_sink (.aclk, .irq_req, .trig(timeout_trigger_out), .gap, .irq_cycles);

   // ---------------------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------------------
   task automatic wr(input logic [5:0] idx, input logic [31:0] v);
      logic a, w, b;
      awaddr  <= {idx, 2'h0};
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge aclk);
         a = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         bp = bresp;
         @(posedge aclk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
   endtask : wr

   task automatic rd(input logic [5:0] idx);
      logic a, v;
      araddr  <= {idx, 2'h0};
      arvalid <= 1'b1;
      v = 1'b0;
      while (!v) begin
         @(negedge aclk);
         a = arvalid & arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (a) arvalid <= 1'b0;
      end
   endtask : rd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   // ---------------------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(6'h0e);
      chk(d, 32'h0);
      rd(6'h3f);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(6'h3f, 32'h0);
      chk(32'(bp), 32'(RESP_SLVERR));
      $display("reset test done");
      wr(6'h06, 32'h000000ff);
      wr(6'h08, 32'h00000001);
      wr(6'h03, 32'h0);
      wr(6'h02, 32'h1);
      wr(6'h00, 32'h80);
      repeat (1100) @(posedge aclk);
      chk(32'(gap), 32'd512);
      while (timeout_trigger_out[0] !== 1'b1) @(posedge aclk);
      @(posedge aclk);
      rd(6'h05);
      chk(d, 32'h1);
      chk(32'(irq_req), 32'h0);
      wr(6'h04, 32'h1);
      chk(32'(irq_req), 32'h1);
      wr(6'h05, 32'h0);
      rd(6'h05);
      chk(d, 32'h1);
      wr(6'h05, 32'h1);
      rd(6'h05);
      chk(d, 32'h0);
      chk(32'(irq_req), 32'h0);
      chk(32'(irq_cycles), 32'd8);
      $display("time-out test done");
      while (timeout_trigger_out[0] !== 1'b1) @(posedge aclk);
      @(posedge aclk);
      wr(6'h02, 32'h0);
      rd(6'h05);
      chk(d, 32'h0);
      wr(6'h0a, 32'h0000ffff);
      chk(32'(bp), 32'(RESP_OKAY));
      rd(6'h0a);
      chk(d, 32'h1);
      $display("disable test done");
      end_of_test();
   end

   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      end_of_test();
   end
endmodule : periodic_timer_channel_regs_tb
